// >>> src/pctd_defs.vh
// constants for the power condition timer descriptor
`ifndef PCTD_DEFS_VH
`define PCTD_DEFS_VH

// descriptor dword offsets (byte addresses in the log descriptor)
`define PCTD_OFS_FLAGS 8'h00
`define PCTD_OFS_FACTORY 8'h04
`define PCTD_OFS_STORED 8'h08
`define PCTD_OFS_ACTIVE 8'h0C
`define PCTD_OFS_WAKE 8'h10
`define PCTD_OFS_LOWER 8'h14
`define PCTD_OFS_UPPER 8'h18
`define PCTD_DESC_LAST 8'h3F

// flag byte (descriptor byte 1) bit positions
`define PCTD_FLG_SUPPORTED 7
`define PCTD_FLG_SAVABLE 6
`define PCTD_FLG_CHANGEABLE 5
`define PCTD_FLG_DEF_EN 4
`define PCTD_FLG_SAVED_EN 3
`define PCTD_FLG_CUR_EN 2

// saturated field value
`define PCTD_SATURATED 32'hFFFFFFFF

// timing: one timer unit is 100 ms, clock period 8 ns
`define PCTD_UNIT_MS 100
`define PCTD_CLK_PERIOD_NS 8
`define PCTD_TICK_CYCLES ((`PCTD_UNIT_MS * 1000000) / `PCTD_CLK_PERIOD_NS)

`endif

// >>> src/pctd_tick_gen.v
// free-running divider making one pulse per 100 ms timer unit
`timescale 1ns/1ps
module pctd_tick_gen #(
  parameter [31:0] TICK_CYCLES = 32'd12500000
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // restart from zero
  input wire restart,
  // one-cycle pulse per unit
  output reg tick_ff
);

reg [31:0] cnt_ff;
reg [31:0] nxt_cnt;
reg nxt_tick;

always @* begin
  nxt_cnt = cnt_ff + 32'h00000001;
  nxt_tick = 1'b0;
  if (restart) begin
    nxt_cnt = 32'h00000000;
  end else if (cnt_ff >= TICK_CYCLES - 32'h00000001) begin
    nxt_cnt = 32'h00000000;
    nxt_tick = 1'b1;
  end
end

always @(posedge mclk or posedge rst) begin
  if (rst) begin
    cnt_ff <= 32'h00000000;
    tick_ff <= 1'b0;
  end else begin
    cnt_ff <= nxt_cnt;
    tick_ff <= nxt_tick;
  end
end

endmodule // pctd_tick_gen

// >>> src/pctd_descriptor.v
// power condition timer descriptor: flags, timer fields and idle timer
// Functional notes
// - supported flag reports whether this power condition exists, regardless of feature enable.
// - current-timer-enabled flag reads zero while extended power conditions disabled.
// - timer runs only with feature enabled, nonzero setting and current flag set.
// - feature enabled with current flag clear keeps the timer stopped.
// - default and saved enable flags valid whenever supported, feature state irrelevant.
// - every timer, recovery and limit field is a 32-bit count of 100 ms.
// - all ones means at or above the largest time; saturated, not exact.
// - default timer is fixed at manufacture, reported when supported.
// - saved timer holds the value last saved by the host subcommand.
// - with feature enabled, saved timer zero means condition disabled.
// - enter condition no sooner than current setting after command completion.
// - current setting reads zero if feature off, unsupported or current flag clear.
// - recovery time reports nominal return time to active state, excluding command.
// - recovery time zero means not specified.
// - lower limit is smallest accepted timer value; zero means unspecified. Code also accepts a zero timer value below the lower limit.
// - upper limit is largest accepted timer value; zero means unspecified.
// - recovery time is unchanged by every kind of reset.
`timescale 1ns/1ps
`include "pctd_defs.vh"
module pctd_descriptor #(
  parameter [31:0] TICK_CYCLES = `PCTD_TICK_CYCLES,
  parameter [0:0] COND_SUPPORTED = 1'b1,
  parameter [0:0] TIMER_SAVABLE = 1'b1,
  parameter [0:0] TIMER_CHANGEABLE = 1'b1,
  parameter [31:0] FACTORY_TIMER = 32'h00000032,
  parameter [31:0] WAKE_TIME = 32'h00000014,
  parameter [31:0] LOWER_LIMIT = 32'h00000001,
  parameter [31:0] UPPER_LIMIT = 32'h0000FFFF
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // feature state
  input wire extended_power_conditions,
  // host timer updates: set current and optionally save
  input wire set_timer,
  input wire [31:0] set_timer_value,
  input wire set_timer_enable,
  input wire set_timer_save,
  // restore default or saved into current
  input wire restore_default,
  input wire restore_saved,
  // command activity
  input wire cmd_done,
  input wire cmd_busy,
  // wake back to active_power_state
  input wire wake,
  // log read port
  input wire [7:0] rd_addr,
  output reg [31:0] rd_data_ff,
  // power condition entry
  output wire enter_req,
  output reg in_condition_ff
);

////////////////////////////////////////////////////////////////////////
// state

reg def_en_ff;
reg saved_en_ff;
reg cur_en_ff;
reg [31:0] saved_ff;
reg [31:0] cur_ff;
reg [31:0] idle_ff;
reg [31:0] nxt_idle;
reg [31:0] nxt_rd;
reg nxt_in;
wire tick;
wire timer_run;
wire cur_en_rep;
wire [31:0] cur_rep;
wire value_ok;
wire set_go;
wire restore_def_go;
wire restore_sav_go;
reg [31:0] nxt_saved;
reg [31:0] nxt_cur;
reg nxt_saved_en;
reg nxt_cur_en;
wire idle_elapsed;
wire cur_finite;
wire cond_stop;
reg [2:0] cond_state_ff;
reg [2:0] nxt_state;
wire [7:0] flag_byte;
wire [31:0] field_val [0:6];
wire [55:0] field_ofs;
wire [6:0] field_sel;
integer fi;
genvar gi;

// condition states, one-hot
localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_COUNT = 3'b010;
localparam [2:0] ST_ENTERED = 3'b100;

////////////////////////////////////////////////////////////////////////
// decode functions

// a value within the limits or zero, zero limits meaning unspecified
function limit_ok;
  input [31:0] v;
  begin
    limit_ok = ((LOWER_LIMIT == 32'h00000000) || (v >= LOWER_LIMIT) || (v == 32'h00000000)) &&
      ((UPPER_LIMIT == 32'h00000000) || (v <= UPPER_LIMIT));
  end
endfunction

// fields that only mean something when the condition exists
function [31:0] sup_only;
  input [31:0] v;
  begin
    sup_only = COND_SUPPORTED ? v : 32'h00000000;
  end
endfunction

// dword-aligned match of a log offset
function dword_hit;
  input [7:0] addr;
  input [7:0] ofs;
  begin
    dword_hit = (addr == ofs);
  end
endfunction

////////////////////////////////////////////////////////////////////////
// host side settings

assign value_ok = limit_ok(set_timer_value);

// a refused value lets a restore in the same cycle through
assign set_go = COND_SUPPORTED && set_timer && value_ok && TIMER_CHANGEABLE;
assign restore_def_go = COND_SUPPORTED && !set_go && restore_default;
assign restore_sav_go = COND_SUPPORTED && !set_go && !restore_default && restore_saved;

////////////////////////////////////////////////////////////////////////
// setting updates

always @* begin
  nxt_saved = saved_ff;
  nxt_saved_en = saved_en_ff;
  nxt_cur = cur_ff;
  nxt_cur_en = cur_en_ff;
  if (set_go) begin
    nxt_cur = set_timer_value;
    nxt_cur_en = set_timer_enable;
    if (set_timer_save && TIMER_SAVABLE) begin
      nxt_saved = set_timer_value;
      nxt_saved_en = set_timer_enable;
    end
  end else if (restore_def_go) begin
    nxt_cur = FACTORY_TIMER;
    nxt_cur_en = def_en_ff;
  end else if (restore_sav_go) begin
    nxt_cur = saved_ff;
    nxt_cur_en = saved_en_ff && (saved_ff != 32'h00000000);
  end
end

// default enable is fixed, so it only ever takes its reset value
always @(posedge mclk or posedge rst) begin
  if (rst) begin
    def_en_ff <= 1'b1;
    saved_en_ff <= 1'b1;
    cur_en_ff <= 1'b1;
    saved_ff <= FACTORY_TIMER;
    cur_ff <= FACTORY_TIMER;
  end else begin
    saved_en_ff <= nxt_saved_en;
    cur_en_ff <= nxt_cur_en;
    saved_ff <= nxt_saved;
    cur_ff <= nxt_cur;
  end
end

////////////////////////////////////////////////////////////////////////
// reported current fields

assign cur_en_rep = COND_SUPPORTED && extended_power_conditions && cur_en_ff;
assign cur_rep = cur_en_rep ? cur_ff : 32'h00000000;

////////////////////////////////////////////////////////////////////////
// idle timer

assign timer_run = cur_en_rep && (cur_rep != 32'h00000000);

pctd_tick_gen #(
  .TICK_CYCLES(TICK_CYCLES)
) u_tick (
  .mclk(mclk),
  .rst(rst),
  .restart(cmd_done),
  .tick_ff(tick)
);

always @* begin
  nxt_idle = idle_ff;
  if (cmd_done || cmd_busy || !timer_run) begin
    nxt_idle = 32'h00000000;
  end else if (tick && idle_ff != `PCTD_SATURATED) begin
    nxt_idle = idle_ff + 32'h00000001;
  end
end

////////////////////////////////////////////////////////////////////////
// entry request

// request only after full setting elapsed
assign idle_elapsed = idle_ff >= cur_rep;
// all ones setting never expires exactly, it just waits at saturation
assign cur_finite = cur_rep != `PCTD_SATURATED;
assign enter_req = timer_run && !cmd_busy && !cmd_done && !in_condition_ff && idle_elapsed && cur_finite;

////////////////////////////////////////////////////////////////////////
// condition state machine

// any activity or a disabled timer drops back to active
assign cond_stop = wake || cmd_busy || cmd_done || !timer_run;

always @* begin
  nxt_state = cond_state_ff;
  if (cond_stop) begin
    nxt_state = ST_IDLE;
  end else begin
    case (cond_state_ff)
      ST_IDLE: begin
        nxt_state = enter_req ? ST_ENTERED : ST_COUNT;
      end
      ST_COUNT: begin
        nxt_state = enter_req ? ST_ENTERED : ST_COUNT;
      end
      ST_ENTERED: begin
        nxt_state = ST_ENTERED;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end
  nxt_in = (nxt_state == ST_ENTERED);
end

always @(posedge mclk or posedge rst) begin
  if (rst) begin
    idle_ff <= 32'h00000000;
    cond_state_ff <= ST_IDLE;
    in_condition_ff <= 1'b0;
  end else begin
    idle_ff <= nxt_idle;
    cond_state_ff <= nxt_state;
    in_condition_ff <= nxt_in;
  end
end

////////////////////////////////////////////////////////////////////////
// log read

////////////////////////////////////////////////////////////////////////
// flag byte

// reserved flag bits 1..0 are zero
assign flag_byte[1:0] = 2'b00;
assign flag_byte[`PCTD_FLG_CUR_EN] = cur_en_rep;
assign flag_byte[`PCTD_FLG_SAVED_EN] = COND_SUPPORTED && saved_en_ff;
assign flag_byte[`PCTD_FLG_DEF_EN] = COND_SUPPORTED && def_en_ff;
assign flag_byte[`PCTD_FLG_CHANGEABLE] = COND_SUPPORTED && TIMER_CHANGEABLE;
assign flag_byte[`PCTD_FLG_SAVABLE] = COND_SUPPORTED && TIMER_SAVABLE;
assign flag_byte[`PCTD_FLG_SUPPORTED] = COND_SUPPORTED;

////////////////////////////////////////////////////////////////////////
// field table

// entry 0 sits in the low byte of the offset list
assign field_ofs = {`PCTD_OFS_UPPER, `PCTD_OFS_LOWER, `PCTD_OFS_WAKE, `PCTD_OFS_ACTIVE,
  `PCTD_OFS_STORED, `PCTD_OFS_FACTORY, `PCTD_OFS_FLAGS};

// reserved bytes 0, 2 and 3 of the flag dword
assign field_val[0] = {16'h0000, flag_byte, 8'h00};
assign field_val[1] = sup_only(FACTORY_TIMER);
assign field_val[2] = sup_only(saved_ff);
assign field_val[3] = cur_rep;
// constant, so no reset alters it
assign field_val[4] = WAKE_TIME;
assign field_val[5] = LOWER_LIMIT;
assign field_val[6] = UPPER_LIMIT;

////////////////////////////////////////////////////////////////////////
// field select

generate
  for (gi = 0; gi < 7; gi = gi + 1) begin : g_sel
    assign field_sel[gi] = dword_hit(rd_addr, field_ofs[gi * 8 +: 8]);
  end
endgenerate

// at most one select is high, so an or of the hits is the mux
// reserved tail and unaligned offsets fall through to zero
always @* begin
  nxt_rd = 32'h00000000;
  for (fi = 0; fi < 7; fi = fi + 1) begin
    if (field_sel[fi]) begin
      nxt_rd = nxt_rd | field_val[fi];
    end
  end
end

always @(posedge mclk or posedge rst) begin
  if (rst) begin
    rd_data_ff <= 32'h00000000;
  end else begin
    rd_data_ff <= nxt_rd;
  end
end

endmodule // pctd_descriptor

// >>> test/pctd_assertions.sv
// concurrent checks on the descriptor ports
`timescale 1ns/1ps
module pctd_checker (
  // clock and reset
  input wire mclk,
  input wire rst,
  // controls
  input wire extended_power_conditions,
  input wire set_timer,
  input wire [31:0] set_timer_value,
  input wire set_timer_enable,
  input wire set_timer_save,
  input wire restore_default,
  input wire restore_saved,
  input wire cmd_done,
  input wire cmd_busy,
  input wire wake,
  // read port and status
  input wire [7:0] rd_addr,
  input wire [31:0] rd_data_ff,
  input wire enter_req,
  input wire in_condition_ff
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  chk_cur_flag_off: assert property (!extended_power_conditions[*2] ##0 rd_addr == 8'h00 |=> !rd_data_ff[10])
    else $error("flag set while off");
  chk_cur_zero: assert property (!extended_power_conditions[*2] ##0 rd_addr == 8'h0C |=> rd_data_ff == 32'h0)
    else $error("current not zero");
  chk_flag_rsvd: assert property (rd_addr == 8'h00 |=> rd_data_ff[31:16] == 16'h0 && rd_data_ff[9:0] == 10'h0)
    else $error("reserved bits set");
  chk_unmapped_zero: assert property (rd_addr > 8'h18 || rd_addr[1:0] != 2'h0 |=> rd_data_ff == 32'h0)
    else $error("unmapped not zero");
  chk_wake_time: assert property (rd_addr == 8'h10 |=> rd_data_ff == 32'h00000014)
    else $error("recovery time wrong");
  chk_supported: assert property (rd_addr == 8'h00 |=> rd_data_ff[15])
    else $error("supported flag low");
  chk_factory: assert property (rd_addr == 8'h04 |=> rd_data_ff == 32'h00000032)
    else $error("factory timer wrong");
  chk_entry_gate: assert property (enter_req |-> extended_power_conditions && !cmd_busy)
    else $error("entry while gated");
  chk_idle_restart: assert property (cmd_done |=> !enter_req[*3])
    else $error("entry too soon");
  chk_enter_cause: assert property ($rose(in_condition_ff) |-> $past(enter_req))
    else $error("entry without request");
  cover property (enter_req ##1 in_condition_ff);
  cover property (wake && in_condition_ff);
  cover property (rd_addr == 8'h0C ##1 rd_data_ff != 32'h0);
endmodule // pctd_checker

bind pctd_descriptor pctd_checker chk_i (.mclk, .rst, .extended_power_conditions, .set_timer, .set_timer_value,
  .set_timer_enable, .set_timer_save, .restore_default, .restore_saved, .cmd_done, .cmd_busy, .wake, .rd_addr,
  .rd_data_ff, .enter_req, .in_condition_ff);

// >>> test/pctd_host_model.sv
// host side: issues descriptor log reads
`timescale 1ns/1ps
module pctd_host_model (
  // clock
  input wire mclk,
  // read request
  output reg [7:0] rd_addr,
  output reg rd_go
);
  initial begin
    rd_addr = 8'h00;
    rd_go = 1'b0;
  end
  // address held after the read, as a real host leaves it
  task read(input [7:0] a);
    @(posedge mclk);
    rd_addr <= a;
    rd_go <= 1'b1;
    @(posedge mclk);
    rd_go <= 1'b0;
  endtask
endmodule // pctd_host_model

// >>> test/pctd_descriptor_tb_top.sv
// testbench for the power condition timer descriptor
`timescale 1ns/1ps
module pctd_descriptor_tb_top;
  reg mclk = 0, rst = 1, extended_power_conditions = 1, set_timer = 0, set_timer_enable = 0, set_timer_save = 0;
  reg restore_default = 0, restore_saved = 0, cmd_done = 0, cmd_busy = 0, wake = 0, go_d = 0;
  reg [31:0] set_timer_value = 32'h0;
  wire [7:0] rd_addr;
  wire rd_go, enter_req, in_condition_ff;
  wire [31:0] rd_data_ff;
  int fails = 0, comparisons = 0, n;
  logic [31:0] v;
  logic [31:0] exp_q[$];
  always #4 mclk = ~mclk;
  // short tick keeps the idle timer test brief
  pctd_descriptor #(.TICK_CYCLES(32'd4)) dut (.mclk, .rst, .extended_power_conditions, .set_timer, .set_timer_value,
    .set_timer_enable, .set_timer_save, .restore_default, .restore_saved, .cmd_done, .cmd_busy, .wake, .rd_addr,
    .rd_data_ff, .enter_req, .in_condition_ff);
  pctd_host_model host (.mclk(mclk), .rd_addr(rd_addr), .rd_go(rd_go));
  task chk(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      fails++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    exp_q.push_back(e);
    host.read(a);
  endtask
  task set_t(input [31:0] val, input en, input sv);
    @(posedge mclk);
    {set_timer, set_timer_value, set_timer_enable, set_timer_save} <= {1'b1, val, en, sv};
    @(posedge mclk);
    set_timer <= 1'b0;
  endtask
  task ctl(input [3:0] p);
    @(posedge mclk);
    {wake, cmd_done, restore_saved, restore_default} <= p;
    @(posedge mclk);
    {wake, cmd_done, restore_saved, restore_default} <= 4'h0;
  endtask
  task summarize;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge mclk) go_d <= rd_go;
  always @(negedge mclk) if (go_d) chk(rd_data_ff, exp_q.pop_front());
  initial begin
    v = $urandom(86);
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    rd(8'h00, 32'h0000FC00);
    rd(8'h04, 32'h00000032);
    rd(8'h08, 32'h00000032);
    rd(8'h0C, 32'h00000032);
    rd(8'h10, 32'h00000014);
    rd(8'h14, 32'h00000001);
    rd(8'h18, 32'h0000FFFF);
    rd(8'($urandom_range(255, 25)), 32'h0);
    extended_power_conditions <= 1'b0;
    rd(8'h00, 32'h0000F800);
    rd(8'h0C, 32'h0);
    extended_power_conditions <= 1'b1;
    v = 32'($urandom_range(32'hFFFF, 1));
    set_t(v, 1'b1, 1'b1);
    rd(8'h0C, v);
    rd(8'h08, v);
    // above the upper limit: silently ignored
    set_t(32'h00010000, 1'b1, 1'b0);
    rd(8'h0C, v);
    set_t(32'h5, 1'b0, 1'b0);
    rd(8'h00, 32'h0000F800);
    rd(8'h0C, 32'h0);
    ctl(4'b0010);
    rd(8'h0C, v);
    ctl(4'b0001);
    rd(8'h0C, 32'h00000032);
    set_t(32'h2, 1'b1, 1'b0);
    ctl(4'b0100);
    n = 0;
    while (enter_req !== 1'b1 && n < 100) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(32'(n >= 8 && n <= 12), 32'h1);
    @(posedge mclk);
    #1 chk(in_condition_ff, 32'h1);
    ctl(4'b1000);
    #1 chk(in_condition_ff, 32'h0);
    @(posedge mclk);
    cmd_busy <= 1'b1;
    @(posedge mclk);
    #1 chk(enter_req, 32'h0);
    chk(in_condition_ff, 32'h0);
    @(posedge mclk);
    cmd_busy <= 1'b0;
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    rd(8'h10, 32'h00000014);
    rd(8'h0C, 32'h00000032);
    repeat (2) @(posedge mclk);
    summarize;
  end
  initial begin
    repeat (2000) @(posedge mclk);
    fails++;
    summarize;
  end
endmodule // pctd_descriptor_tb_top
